// file: rtl/msq_defines.svh
`ifndef MSQ_DEFINES_SVH
`define MSQ_DEFINES_SVH

// Conversion clock periods spent sampling after start
`define MSQ_SAMPLE_CYCLES  6'h20
// Abort window measured from start in conversion clock periods
`define MSQ_ABORT_WINDOW   7'h40
// Result width and channel address width
`define MSQ_RESULT_BITS    8
`define MSQ_CHAN_BITS      3
// Weight of the first bit trial
`define MSQ_FIRST_WEIGHT   8'h80
// Output latch value after a start clears it
`define MSQ_RESULT_RESET   8'h00

`endif

// file: rtl/msq_pkg.sv
package msq_pkg;

   typedef enum logic [3:0]
   {
      MSQ_IDLE   = 4'b0001,
      MSQ_SAMPLE = 4'b0010,
      MSQ_TRIAL  = 4'b0100,
      MSQ_DONE   = 4'b1000
   } msq_state_t;

endpackage

// file: rtl/msq_trial_if.sv
`timescale 1ns/1ps
// Bit trial handshake between the sequencer and the trial engine
interface msq_trial_if;
   logic       clear;
   logic       step;
   logic       above;
   logic [7:0] weight;
   logic [7:0] code;
   logic       last;

   modport ctrl
   (
      output clear,
      output step,
      output above,
      input  weight,
      input  code,
      input  last
   );

   modport engine
   (
      input  clear,
      input  step,
      input  above,
      output weight,
      output code,
      output last
   );
endinterface

// file: rtl/msq_bit_trial.sv
`timescale 1ns/1ps
`include "msq_defines.svh"
module msq_bit_trial
   import msq_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   msq_trial_if.engine trial
);

   typedef struct packed
   {
      logic [7:0] weight;
      logic [7:0] code;
   } msq_trial_state_t;

   msq_trial_state_t st_reg;
   msq_trial_state_t st_next;

   // Weight walks from the top bit down, one trial per step
   always_comb
   begin
      st_next = st_reg;
      if (trial.clear)
      begin
         st_next.weight = `MSQ_FIRST_WEIGHT;
         st_next.code   = 8'h00;
      end
      else if (trial.step && (st_reg.weight != 8'h00))
      begin
         if (trial.above)
            st_next.code = st_reg.code | st_reg.weight;
         st_next.weight = st_reg.weight >> 1;
      end
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_reg <= '{weight: 8'h00, code: 8'h00};
      else
         st_reg <= st_next;
   end

   assign trial.weight = st_reg.weight;
   assign trial.code   = st_reg.code;
   assign trial.last   = (st_reg.weight == 8'h01);

   AST_WEIGHT_HALVES: assert property (@(posedge clk_i) disable iff (rst_i)
      (trial.step && !trial.clear && st_reg.weight != 8'h00) |=> (st_reg.weight == $past(st_reg.weight) >> 1))
      else $error("Trial weight did not halve");

   AST_KEEP_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
      (trial.step && !trial.clear && trial.above && st_reg.weight != 8'h00)
      |=> ((st_reg.code & $past(st_reg.weight)) != 8'h00))
      else $error("Bit not recorded for high comparator");

endmodule

// file: rtl/msq_sequencer.sv
// How it works
// - Route one of eight inputs by address.
// - Address captured on strobe rising edge.
// - Start rising edge clears output latch.
// - Sample 32 clocks after start edge.
// - Early new start restarts conversion.
// - Aborted result never reaches output latch.
// - Resolve bits from MSB to LSB.
// - Eight trials, then cycle may repeat.
// - Keep bit when node above threshold.
// - Repeat with halved weights down to LSB.
// - Three-bit address decoded to eight selects.
// - Result latch drives three-state outputs.
`timescale 1ns/1ps
`include "msq_defines.svh"
module msq_sequencer
   import msq_pkg::*;
#(
   parameter int SAMPLE_CYCLES = `MSQ_SAMPLE_CYCLES,
   parameter int RESULT_BITS   = `MSQ_RESULT_BITS
)
(
   input  wire logic       CORE_CLK_I,
   input  wire logic       RST_I,
   input  wire logic [2:0] CHAN_ADDR_I,
   input  wire logic       ADDR_LOAD_I,
   input  wire logic       START_I,
   input  wire logic       OUT_ENABLE_I,
   input  wire logic       COMP_ABOVE_I,
   output logic      [7:0] CHAN_SEL_O,
   output logic            SAMPLE_O,
   output logic      [7:0] TRIAL_WEIGHT_O,
   output logic      [7:0] RESULT_O,
   output logic      [7:0] RESULT_OE_O,
   output logic            EOC_O
);

   // Logic is built for eight result bits and a six-bit sample counter
   if (RESULT_BITS != `MSQ_RESULT_BITS || SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 63)
   begin : g_bad_params
      $error("Unsupported sequencer parameters");
   end

   typedef struct packed
   {
      msq_state_t state;
      logic [5:0] count;
      logic [2:0] addr;
      logic       load_d;
      logic       start_d;
      logic [7:0] result;
      logic       eoc;
   } msq_seq_state_t;

   msq_seq_state_t st_reg;
   msq_seq_state_t st_next;

   // Trial handshake to the engine
   msq_trial_if trial_bus();

   logic start_edge;
   logic load_edge;

   // Delayed copies reset low, matching idle pins, so no false edge
   assign start_edge = START_I & ~st_reg.start_d;
   assign load_edge  = ADDR_LOAD_I & ~st_reg.load_d;

   // Sequence control; a start edge overrides every state
   always_comb
   begin
      st_next         = st_reg;
      st_next.start_d = START_I;
      st_next.load_d  = ADDR_LOAD_I;
      trial_bus.clear = 1'b0;
      trial_bus.step  = 1'b0;
      trial_bus.above = COMP_ABOVE_I;
      if (load_edge)
         st_next.addr = CHAN_ADDR_I;
      if (start_edge)
      begin
         st_next.result  = `MSQ_RESULT_RESET;
         st_next.eoc     = 1'b0;
         st_next.count   = 6'h00;
         st_next.state   = MSQ_SAMPLE;
         trial_bus.clear = 1'b1;
      end
      else
      begin
         case (st_reg.state)
            MSQ_IDLE:
               st_next.state = MSQ_IDLE;
            MSQ_SAMPLE:
            begin
               if (st_reg.count == 6'(SAMPLE_CYCLES - 1))
                  st_next.state = MSQ_TRIAL;
               else
                  st_next.count = st_reg.count + 6'h01;
            end
            MSQ_TRIAL:
            begin
               trial_bus.step = 1'b1;
               if (trial_bus.last)
                  st_next.state = MSQ_DONE;
            end
            MSQ_DONE:
            begin
               st_next.result = trial_bus.code;
               st_next.eoc    = 1'b1;
               st_next.state  = MSQ_IDLE;
            end
            default:
               st_next.state = MSQ_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
         st_reg <= '{state: MSQ_IDLE, count: 6'h00, addr: 3'h0, load_d: 1'b0,
                     start_d: 1'b0, result: `MSQ_RESULT_RESET, eoc: 1'b0};
      else
         st_reg <= st_next;
   end

   msq_bit_trial u_trial
   (
      .clk_i (CORE_CLK_I),
      .rst_i (RST_I),
      .trial (trial_bus.engine)
   );

   always_comb
   begin
      CHAN_SEL_O = 8'h00;
      CHAN_SEL_O[st_reg.addr] = 1'b1;
   end

   assign SAMPLE_O       = (st_reg.state == MSQ_SAMPLE);
   assign TRIAL_WEIGHT_O = (st_reg.state == MSQ_TRIAL) ? trial_bus.weight : 8'h00;
   assign RESULT_O       = st_reg.result;
   assign RESULT_OE_O    = {8{OUT_ENABLE_I}};
   assign EOC_O          = st_reg.eoc;

   AST_START_CLEARS: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      start_edge |=> (RESULT_O == 8'h00 && !EOC_O))
      else $error("Start did not clear latch");

   AST_SAMPLE_LEN: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (start_edge ##1 (!start_edge)[*8] ##1 (!start_edge)[*8] ##1 (!start_edge)[*8] ##1 (!start_edge)[*8])
      |-> (SAMPLE_O ##1 !SAMPLE_O))
      else $error("Sampling length wrong");

   AST_RESTART: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      start_edge |=> (SAMPLE_O && st_reg.count == 6'h00))
      else $error("Start did not restart sequence");

   AST_NO_PARTIAL: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (st_reg.state == MSQ_SAMPLE || st_reg.state == MSQ_TRIAL) |-> (RESULT_O == 8'h00 && !EOC_O))
      else $error("Result leaked during conversion");

   AST_EIGHT_TRIALS: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      ($rose(st_reg.state == MSQ_TRIAL) ##0 (!start_edge)[*8]) |=> (st_reg.state == MSQ_DONE))
      else $error("Trial count wrong");

   AST_EOC_SET: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (st_reg.state == MSQ_DONE && !start_edge) |=> (EOC_O && RESULT_O == $past(trial_bus.code)))
      else $error("End of conversion not flagged");

   AST_ONE_HOT: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      $onehot(CHAN_SEL_O))
      else $error("Channel select not one-hot");

   AST_ADDR_LOAD: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      load_edge |=> (CHAN_SEL_O == (8'h01 << $past(CHAN_ADDR_I))))
      else $error("Address not captured");

   AST_ADDR_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      !load_edge |=> $stable(CHAN_SEL_O))
      else $error("Channel select changed without strobe");

   AST_EOC_HOLDS: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (EOC_O && !start_edge) |=> (EOC_O && $stable(RESULT_O)))
      else $error("Result or end flag dropped early");

   AST_FIRST_WEIGHT: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      $rose(st_reg.state == MSQ_TRIAL) |-> (TRIAL_WEIGHT_O == `MSQ_FIRST_WEIGHT))
      else $error("First trial weight wrong");

   // one weight per trial, none otherwise
   AST_TRIAL_WEIGHT: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      ((st_reg.state == MSQ_TRIAL) ? $onehot(TRIAL_WEIGHT_O) : (TRIAL_WEIGHT_O == 8'h00)))
      else $error("Trial weight not a single bit");

   AST_DONE_AFTER_LAST: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (st_reg.state == MSQ_TRIAL && trial_bus.weight == 8'h01 && !start_edge) |=> (st_reg.state == MSQ_DONE))
      else $error("Done did not follow last trial");

endmodule

// file: testbench/msq_host_model.sv
`timescale 1ns/1ps
// Host side: channel address, capture strobe, start pulse, read enable
module msq_host_model
(
   input  wire logic       clk_i,
   output logic      [2:0] addr_o,
   output logic            load_o,
   output logic            start_o,
   output logic            oe_o
);
   // Idle levels before the first request
   initial
   begin
      addr_o  = 3'h0;
      load_o  = 1'b0;
      start_o = 1'b0;
      oe_o    = 1'b0;
   end

   // address capture strobe
   // Lines go to the inverse afterwards, so a latch that leaks shows up
   task automatic load_addr(input logic [2:0] a);
      @(posedge clk_i) #2;
      addr_o = a;
      load_o = 1'b1;
      @(posedge clk_i) #2;
      load_o = 1'b0;
      addr_o = ~a;
   endtask

   // one start pulse
   // Low again after one edge so the next start is a fresh rising edge
   task automatic pulse_start();
      @(posedge clk_i) #2;
      start_o = 1'b1;
      @(posedge clk_i) #2;
      start_o = 1'b0;
   endtask

   // Read enable level
   task automatic set_oe(input logic v);
      oe_o = v;
   endtask
endmodule

// file: testbench/tb_muxed_sar_adc_sequencer.sv
`timescale 1ns/1ps
module tb_muxed_sar_adc_sequencer;
   logic       clk;
   logic       rst;
   logic [2:0] addr;
   logic       load;
   logic       start;
   logic       oe;
   logic       comp;
   logic [7:0] pat;
   logic [7:0] sel;
   logic [7:0] wgt;
   logic [7:0] res;
   logic [7:0] res_oe;
   logic       smp;
   logic       eoc;
   int         err_total;
   int         cmp_count;
   int         exp_q[$];

   // Comparator: node above threshold when the trial weight hits a one
   assign comp = |(pat & wgt);

   msq_host_model host
   (
      .clk_i   (clk),
      .addr_o  (addr),
      .load_o  (load),
      .start_o (start),
      .oe_o    (oe)
   );

   msq_sequencer uut
   (
      .CORE_CLK_I     (clk),
      .RST_I          (rst),
      .CHAN_ADDR_I    (addr),
      .ADDR_LOAD_I    (load),
      .START_I        (start),
      .OUT_ENABLE_I   (oe),
      .COMP_ABOVE_I   (comp),
      .CHAN_SEL_O     (sel),
      .SAMPLE_O       (smp),
      .TRIAL_WEIGHT_O (wgt),
      .RESULT_O       (res),
      .RESULT_OE_O    (res_oe),
      .EOC_O          (eoc)
   );

   // 40 MHz conversion clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Start a conversion and follow it; cut > 0 stops early for a restart
   task automatic conv(input logic [7:0] p, input int cut);
      pat = p;
      exp_q.push_back(p);
      host.pulse_start();
      for (int i = 0; i < 41 && (cut == 0 || i < cut); i++)
      begin
         chk({6'h00, eoc, smp}, {7'h00, i < 32});
         chk(res, 8'h00);
         chk(wgt, (i >= 32 && i < 40) ? 8'h80 >> (i - 32) : 8'h00);
         @(posedge clk) #2;
      end
      if (cut == 0)
      begin
         chk({7'h00, eoc}, 8'h01);
         chk(res, 8'(exp_q.pop_front()));
      end
      else
         void'(exp_q.pop_back());
   endtask

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("unexpected at %0t: run did not finish", $time);
      print_verdict();
   end

   initial
   begin
      err_total = 0;
      cmp_count = 0;
      pat = 8'h00;
      rst = 1'b1;
      void'($urandom(78));
      repeat (20) @(posedge clk);
      #2 rst = 1'b0;
      chk(sel, 8'h01);
      chk({6'h00, smp, eoc}, 8'h00);
      // Every channel, then one edge with the lines changed
      for (int a = 0; a < 8; a++)
      begin
         host.load_addr(a[2:0]);
         @(posedge clk) #2;
         chk(sel, 8'h01 << a);
      end
      // Three-state enable follows the read line
      for (int v = 0; v < 2; v++)
      begin
         host.set_oe(v[0]);
         @(posedge clk) #2;
         chk(res_oe, {8{v[0]}});
      end
      conv(8'h00, 0);
      conv(8'hff, 0);
      repeat (4) conv(8'($urandom), 0);
      // Restarts at the window edges and at random points inside it
      conv(8'h5a, 1);
      conv(8'ha5, 0);
      conv(8'h3c, 38);
      conv(8'hc3, 0);
      repeat (3)
      begin
         conv(8'($urandom), 1 + int'($urandom % 38));
         conv(8'($urandom), 0);
      end
      print_verdict();
   end
endmodule
